// ---- src/fbc_handler.sv ----
// module: forced bit command handler top
// Contract
// - force-set command forces the addressed bit on until cancel
// - force-reset command forces the addressed bit off until cancel
// - region operand, bcd word within region range, bit 00 to 15
// - timer/counter operand with number 0000 to 0511, bit always 00
// - special words 253 to 255 are refused
// - in run mode forcing commands answer end code 01 (cancel is still carried out with 00 in run mode)
// - wrong command length answers 14 and forces nothing
// - bad operand, word or bit answers 15
// - multi-force carries one operation code per bit of the word
// - codes: none, write 0, write 1, force off, force on, cancel
// - timer/counter multi-force uses only the bit 15 code
// - timer/counter multi-force allows only force on and off
// - transition flags up to 1023 run without program check
// - cancel command removes every forcing at once
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module fbc_handler #(
    parameter int WORDS = 512,
    parameter int CF_N  = 512,
    parameter int TRN_N = 1024
) (
    input  wire logic                 core_clk,
    input  wire logic                 nrst,
    input  wire logic                 cmd_valid,
    input  wire fbc_pkg::fbc_cmd_type cmd_code,
    input  wire logic [7:0]           cmd_len,
    input  wire logic                 cmd_fcs_bad,
    input  wire logic                 cmd_frame_bad,
    input  wire logic [31:0]          cmd_operand,
    input  wire logic [15:0]          cmd_word,
    input  wire logic [7:0]           cmd_bit,
    input  wire logic [63:0]          cmd_ops,
    input  wire logic [1:0]           plc_mode,
    input  wire logic                 prog_we,
    input  wire logic [8:0]           prog_addr,
    input  wire logic [15:0]          prog_data,
    input  wire logic [8:0]           rd_addr,
    output logic                      rsp_valid,
    output logic [7:0]                rsp_code,
    output logic [15:0]               rd_data,
    output logic [15:0]               rd_forced
);
    initial begin
        if (WORDS != 512 || CF_N != 512 || TRN_N != 1024)
            $error("fbc_handler: map sizes are fixed by the decoder");
    end
    // ********************************************
    // state
    // ********************************************
    // io/special, link, holding, aux words share one 16 bit image each
    typedef struct packed {
        logic [WORDS-1:0][15:0] io;
        logic [WORDS-1:0][15:0] io_fm;
        logic [WORDS-1:0][15:0] io_fv;
        logic [63:0][15:0]      lk;
        logic [63:0][15:0]      lk_fm;
        logic [63:0][15:0]      lk_fv;
        logic [99:0][15:0]      hd;
        logic [99:0][15:0]      hd_fm;
        logic [99:0][15:0]      hd_fv;
        logic [27:0][15:0]      ax;
        logic [27:0][15:0]      ax_fm;
        logic [27:0][15:0]      ax_fv;
        logic [CF_N-1:0]        cf_fm;
        logic [CF_N-1:0]        cf_fv;
        logic [TRN_N-1:0]       trn_fm;
        logic [TRN_N-1:0]       trn_fv;
        logic                   rsp_valid;
        logic [7:0]             rsp_code;
        logic [15:0]            rd_data;
        logic [15:0]            rd_forced;
    } fbc_state_type;
    fbc_state_type state_ff;
    fbc_state_type nxt_state;

    fbc_pkg::fbc_area_type area;
    logic [10:0] word_bin;
    logic [3:0]  bit_bin;
    logic        addr_ok;

    fbc_decode u_decode (
        .operand  (cmd_operand),
        .word_bcd (cmd_word),
        .bit_bcd  (cmd_bit),
        .area     (area),
        .word_bin (word_bin),
        .bit_bin  (bit_bin),
        .addr_ok  (addr_ok)
    );

    // ********************************************
    // per word operation on mask, value and data
    // ********************************************
    function automatic logic [47:0] apply_ops(
        input logic [15:0] d,
        input logic [15:0] fm,
        input logic [15:0] fv,
        input logic [63:0] ops
    );
        logic [15:0] nd;
        logic [15:0] nm;
        logic [15:0] nv;
        nd = d;
        nm = fm;
        nv = fv;
        for (int i = 0; i < 16; i++) begin
            unique case (ops[4*i +: 4])
                fbc_pkg::FBC_OP_WR0: nd[i] = 1'b0;
                fbc_pkg::FBC_OP_WR1: nd[i] = 1'b1;
                fbc_pkg::FBC_OP_FOFF: begin
                    nm[i] = 1'b1;
                    nv[i] = 1'b0;
                end
                fbc_pkg::FBC_OP_FON: begin
                    nm[i] = 1'b1;
                    nv[i] = 1'b1;
                end
                fbc_pkg::FBC_OP_CANCEL: nm[i] = 1'b0;
                default: nd[i] = nd[i];
            endcase
        end
        return {nd, nm, nv};
    endfunction

    // bit 15 code first in the data, so op for bit i sits at ops[4*i]
    function automatic logic ops_legal(input logic [63:0] ops);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 16; i++) begin
            if (!(ops[4*i +: 4] inside {fbc_pkg::FBC_OP_NONE,
                  fbc_pkg::FBC_OP_WR0, fbc_pkg::FBC_OP_WR1,
                  fbc_pkg::FBC_OP_FOFF, fbc_pkg::FBC_OP_FON,
                  fbc_pkg::FBC_OP_CANCEL}))
                ok = 1'b0;
        end
        return ok;
    endfunction

    // ********************************************
    // command execution
    // ********************************************
    logic        is_cf;
    logic        is_bitarea;
    logic        len_ok;
    logic        spec_hit;
    logic [7:0]  code;
    logic [3:0]  cf_op;
    logic [63:0] ops;
    logic [47:0] res;
    logic [15:0] wd;
    logic [15:0] wm;
    logic [15:0] wv;
    always_comb begin
        nxt_state = state_ff;
        nxt_state.rsp_valid = 1'b0;
        is_cf = !(area inside {fbc_pkg::FBC_AREA_IO, fbc_pkg::FBC_AREA_LINK,
                  fbc_pkg::FBC_AREA_HOLD, fbc_pkg::FBC_AREA_AUX,
                  fbc_pkg::FBC_AREA_BAD});
        is_bitarea = !is_cf && area != fbc_pkg::FBC_AREA_BAD;
        len_ok = (cmd_code == fbc_pkg::FBC_CMD_MULTI) ?
                 cmd_len == fbc_pkg::FBC_LEN_MULTI :
                 (cmd_code == fbc_pkg::FBC_CMD_CANCEL) ?
                 cmd_len == 8'h00 : cmd_len == fbc_pkg::FBC_LEN_SINGLE;
        spec_hit = area == fbc_pkg::FBC_AREA_IO &&
                   word_bin >= fbc_pkg::FBC_SPEC_LO &&
                   word_bin <= fbc_pkg::FBC_SPEC_HI;
        cf_op = cmd_ops[4*fbc_pkg::FBC_CF_BIT +: 4];
        // single commands become a one bit operation word
        ops = 64'h0000_0000_0000_0000;
        if (cmd_code == fbc_pkg::FBC_CMD_MULTI)
            ops = cmd_ops;
        else if (cmd_code == fbc_pkg::FBC_CMD_SET)
            ops[4*bit_bin +: 4] = fbc_pkg::FBC_OP_FON;
        else
            ops[4*bit_bin +: 4] = fbc_pkg::FBC_OP_FOFF;
        code = fbc_pkg::FBC_END_OK;
        if (cmd_fcs_bad)
            code = fbc_pkg::FBC_END_CHECKSUM;
        else if (cmd_frame_bad)
            code = fbc_pkg::FBC_END_FRAME;
        else if (!len_ok)
            code = fbc_pkg::FBC_END_FORMAT;
        else if (cmd_code != fbc_pkg::FBC_CMD_CANCEL) begin
            if (plc_mode == fbc_pkg::FBC_MODE_RUN)
                code = fbc_pkg::FBC_END_RUN;
            else if (!addr_ok || spec_hit)
                code = fbc_pkg::FBC_END_ENTRY;
            else if (cmd_code == fbc_pkg::FBC_CMD_MULTI && is_cf &&
                     !(cf_op inside {fbc_pkg::FBC_OP_FON, fbc_pkg::FBC_OP_FOFF}))
                code = fbc_pkg::FBC_END_ENTRY;
            else if (cmd_code == fbc_pkg::FBC_CMD_MULTI && !is_cf &&
                     !ops_legal(cmd_ops))
                code = fbc_pkg::FBC_END_ENTRY;
        end
        res = apply_ops(16'h0000, 16'h0000, 16'h0000, ops);
        wd = 16'h0000;
        wm = 16'h0000;
        wv = 16'h0000;
        if (cmd_valid) begin
            nxt_state.rsp_valid = 1'b1;
            nxt_state.rsp_code  = code;
            if (code == fbc_pkg::FBC_END_OK) begin
                if (cmd_code == fbc_pkg::FBC_CMD_CANCEL) begin
                    nxt_state.io_fm = '0;
                    nxt_state.lk_fm = '0;
                    nxt_state.hd_fm = '0;
                    nxt_state.ax_fm = '0;
                    nxt_state.cf_fm = '0;
                    nxt_state.trn_fm = '0;
                end else if (is_cf) begin
                    // completion flag takes the bit 15 code only
                    if (cmd_code == fbc_pkg::FBC_CMD_MULTI) begin
                        wm[0] = 1'b1;
                        wv[0] = cf_op == fbc_pkg::FBC_OP_FON;
                    end else begin
                        wm[0] = 1'b1;
                        wv[0] = cmd_code == fbc_pkg::FBC_CMD_SET;
                    end
                    if (area == fbc_pkg::FBC_AREA_TRANS) begin
                        nxt_state.trn_fm[word_bin[9:0]] = 1'b1;
                        nxt_state.trn_fv[word_bin[9:0]] = wv[0];
                    end else begin
                        nxt_state.cf_fm[word_bin[8:0]] = wm[0];
                        nxt_state.cf_fv[word_bin[8:0]] = wv[0];
                    end
                end else if (is_bitarea) begin
                    unique case (area)
                        fbc_pkg::FBC_AREA_LINK: begin
                            res = apply_ops(state_ff.lk[word_bin[5:0]],
                                state_ff.lk_fm[word_bin[5:0]],
                                state_ff.lk_fv[word_bin[5:0]], ops);
                            {nxt_state.lk[word_bin[5:0]],
                             nxt_state.lk_fm[word_bin[5:0]],
                             nxt_state.lk_fv[word_bin[5:0]]} = res;
                        end
                        fbc_pkg::FBC_AREA_HOLD: begin
                            res = apply_ops(state_ff.hd[word_bin[6:0]],
                                state_ff.hd_fm[word_bin[6:0]],
                                state_ff.hd_fv[word_bin[6:0]], ops);
                            {nxt_state.hd[word_bin[6:0]],
                             nxt_state.hd_fm[word_bin[6:0]],
                             nxt_state.hd_fv[word_bin[6:0]]} = res;
                        end
                        fbc_pkg::FBC_AREA_AUX: begin
                            res = apply_ops(state_ff.ax[word_bin[4:0]],
                                state_ff.ax_fm[word_bin[4:0]],
                                state_ff.ax_fv[word_bin[4:0]], ops);
                            {nxt_state.ax[word_bin[4:0]],
                             nxt_state.ax_fm[word_bin[4:0]],
                             nxt_state.ax_fv[word_bin[4:0]]} = res;
                        end
                        default: begin
                            res = apply_ops(state_ff.io[word_bin[8:0]],
                                state_ff.io_fm[word_bin[8:0]],
                                state_ff.io_fv[word_bin[8:0]], ops);
                            {nxt_state.io[word_bin[8:0]],
                             nxt_state.io_fm[word_bin[8:0]],
                             nxt_state.io_fv[word_bin[8:0]]} = res;
                        end
                    endcase
                end
            end
        end else if (prog_we) begin
            // program writes hit io words only where no forcing holds
            nxt_state.io[prog_addr] = (prog_data & ~state_ff.io_fm[prog_addr]) |
                (state_ff.io[prog_addr] & state_ff.io_fm[prog_addr]);
        end
        // forced level seen by every reader
        nxt_state.rd_data = (state_ff.io[rd_addr] & ~state_ff.io_fm[rd_addr]) |
            (state_ff.io_fv[rd_addr] & state_ff.io_fm[rd_addr]);
        nxt_state.rd_forced = state_ff.io_fm[rd_addr];
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign rsp_valid = state_ff.rsp_valid;
    assign rsp_code  = state_ff.rsp_code;
    assign rd_data   = state_ff.rd_data;
    assign rd_forced = state_ff.rd_forced;

    // ********************************************
    // checks
    // ********************************************
    chk_one_response: assert property (@(posedge core_clk) disable iff (!nrst)
        cmd_valid |=> rsp_valid) else $error("no response");
    chk_run_refuse: assert property (@(posedge core_clk) disable iff (!nrst)
        cmd_valid && !cmd_fcs_bad && !cmd_frame_bad && len_ok &&
        cmd_code != fbc_pkg::FBC_CMD_CANCEL &&
        plc_mode == fbc_pkg::FBC_MODE_RUN |=> rsp_code == 8'h01)
        else $error("run mode not refused");
    chk_len_refuse: assert property (@(posedge core_clk) disable iff (!nrst)
        cmd_valid && !cmd_fcs_bad && !cmd_frame_bad && !len_ok
        |=> rsp_code == 8'h14 && $stable(state_ff.io_fm))
        else $error("bad length not refused");
    chk_special_refuse: assert property (@(posedge core_clk) disable iff (!nrst)
        cmd_valid && code != fbc_pkg::FBC_END_CHECKSUM && code != 8'h18 &&
        len_ok && spec_hit && plc_mode != fbc_pkg::FBC_MODE_RUN
        |=> rsp_code == 8'h15) else $error("special word accepted");
    chk_cancel_all: assert property (@(posedge core_clk) disable iff (!nrst)
        cmd_valid && code == 8'h00 && cmd_code == fbc_pkg::FBC_CMD_CANCEL
        |=> state_ff.io_fm == '0 && state_ff.cf_fm == '0)
        else $error("forcing left after cancel");
    chk_force_set: assert property (@(posedge core_clk) disable iff (!nrst)
        cmd_valid && code == 8'h00 && cmd_code == fbc_pkg::FBC_CMD_SET &&
        area == fbc_pkg::FBC_AREA_IO |=> state_ff.io_fm[$past(word_bin[8:0])]
        [$past(bit_bin)] && state_ff.io_fv[$past(word_bin[8:0])]
        [$past(bit_bin)]) else $error("force set missing");
    chk_force_reset: assert property (@(posedge core_clk) disable iff (!nrst)
        cmd_valid && code == 8'h00 && cmd_code == fbc_pkg::FBC_CMD_RESET &&
        area == fbc_pkg::FBC_AREA_IO |=> state_ff.io_fm[$past(word_bin[8:0])]
        [$past(bit_bin)] && !state_ff.io_fv[$past(word_bin[8:0])]
        [$past(bit_bin)]) else $error("force reset missing");
    chk_forced_read: assert property (@(posedge core_clk) disable iff (!nrst)
        ##1 ((rd_data ^ $past(state_ff.io_fv[rd_addr])) &
        $past(state_ff.io_fm[rd_addr])) == 16'h0000)
        else $error("forced level lost");
endmodule
`default_nettype wire

// ---- src/fbc_pkg.sv ----
// package: constants and types of the forced bit command handler
`default_nettype none
package fbc_pkg;
    // command codes presented on cmd_code
    typedef enum logic [1:0] {
        FBC_CMD_SET,
        FBC_CMD_RESET,
        FBC_CMD_MULTI,
        FBC_CMD_CANCEL
    } fbc_cmd_type;
    // region selected by the decoded operand
    typedef enum logic [3:0] {
        FBC_AREA_IO,
        FBC_AREA_LINK,
        FBC_AREA_HOLD,
        FBC_AREA_AUX,
        FBC_AREA_TIMER,
        FBC_AREA_FTIMER,
        FBC_AREA_COUNTER,
        FBC_AREA_RCOUNTER,
        FBC_AREA_TTIMER,
        FBC_AREA_TRANS,
        FBC_AREA_BAD
    } fbc_area_type;
    // operating modes
    localparam logic [1:0] FBC_MODE_PROGRAM = 2'h0;
    localparam logic [1:0] FBC_MODE_RUN     = 2'h2;
    localparam logic [1:0] FBC_MODE_MONITOR = 2'h3;
    // end codes (two bcd digits)
    localparam logic [7:0] FBC_END_OK     = 8'h00;
    localparam logic [7:0] FBC_END_RUN    = 8'h01;
    localparam logic [7:0] FBC_END_CHECKSUM = 8'h13;
    localparam logic [7:0] FBC_END_FORMAT = 8'h14;
    localparam logic [7:0] FBC_END_ENTRY  = 8'h15;
    localparam logic [7:0] FBC_END_FRAME  = 8'h18;
    // expected body lengths in characters (operand+word+bit / +data)
    localparam logic [7:0] FBC_LEN_SINGLE = 8'h0a;
    localparam logic [7:0] FBC_LEN_MULTI  = 8'h1a;
    // per bit operation codes
    localparam logic [3:0] FBC_OP_NONE    = 4'h0;
    localparam logic [3:0] FBC_OP_WR0     = 4'h2;
    localparam logic [3:0] FBC_OP_WR1     = 4'h3;
    localparam logic [3:0] FBC_OP_FOFF    = 4'h4;
    localparam logic [3:0] FBC_OP_FON     = 4'h5;
    localparam logic [3:0] FBC_OP_CANCEL  = 4'h8;
    // highest word addresses per region, special word range, flag bit
    localparam logic [10:0] FBC_MAX_IO    = 11'h1ff;
    localparam logic [10:0] FBC_MAX_LINK  = 11'h03f;
    localparam logic [10:0] FBC_MAX_HOLD  = 11'h063;
    localparam logic [10:0] FBC_MAX_AUX   = 11'h01b;
    localparam logic [10:0] FBC_MAX_CF    = 11'h1ff;
    localparam logic [10:0] FBC_MAX_TRANS = 11'h3ff;
    localparam logic [10:0] FBC_SPEC_LO   = 11'h0fd;
    localparam logic [10:0] FBC_SPEC_HI   = 11'h0ff;
    localparam logic [3:0]  FBC_CF_BIT    = 4'hf;
    // reset values
    localparam logic [7:0] FBC_RST_CODE   = 8'h00;
endpackage
`default_nettype wire

// ---- src/fbc_decode.sv ----
// module: operand and address decoder of the forced bit command handler
`timescale 1ns/1ns
`default_nettype none
module fbc_decode (
    input  wire logic [31:0]          operand,
    input  wire logic [15:0]          word_bcd,
    input  wire logic [7:0]           bit_bcd,
    output fbc_pkg::fbc_area_type     area,
    output logic [10:0]               word_bin,
    output logic [3:0]                bit_bin,
    output logic                      addr_ok
);
    // ********************************************
    // bcd conversion
    // ********************************************
    logic        bcd_ok;
    logic [6:0]  bit_tmp;
    logic [13:0] word_tmp;
    always_comb begin
        bcd_ok = (word_bcd[15:12] < 4'ha) && (word_bcd[11:8] < 4'ha) &&
                 (word_bcd[7:4] < 4'ha) && (word_bcd[3:0] < 4'ha) &&
                 (bit_bcd[7:4] < 4'ha) && (bit_bcd[3:0] < 4'ha);
        word_tmp = 14'(word_bcd[15:12] * 10'd1000) +
                   14'(word_bcd[11:8] * 7'd100) +
                   14'(word_bcd[7:4] * 4'd10) + 14'(word_bcd[3:0]);
        bit_tmp  = 7'(bit_bcd[7:4] * 4'd10) + 7'(bit_bcd[3:0]);
        word_bin = word_tmp[10:0];
        bit_bin  = bit_tmp[3:0];
    end
    // ********************************************
    // operand match and range check
    // ********************************************
    always_comb begin
        unique case (operand)
            "CIO ": area = fbc_pkg::FBC_AREA_IO;
            "LR  ": area = fbc_pkg::FBC_AREA_LINK;
            "HR  ": area = fbc_pkg::FBC_AREA_HOLD;
            "AR  ": area = fbc_pkg::FBC_AREA_AUX;
            "TIM ": area = fbc_pkg::FBC_AREA_TIMER;
            "FAST_TIMER_INSTRUCTION": area = fbc_pkg::FBC_AREA_FTIMER;
            "CNT ": area = fbc_pkg::FBC_AREA_COUNTER;
            "REVERSIBLE_COUNTER_INSTRUCTION": area = fbc_pkg::FBC_AREA_RCOUNTER;
            "TOTALIZING_TIMER_INSTRUCTION": area = fbc_pkg::FBC_AREA_TTIMER;
            "TN  ": area = fbc_pkg::FBC_AREA_TRANS;
            default: area = fbc_pkg::FBC_AREA_BAD;
        endcase
        addr_ok = 1'b0;
        if (bcd_ok && word_tmp < 14'h0800) begin
            unique case (area)
                fbc_pkg::FBC_AREA_IO:
                    addr_ok = word_bin <= fbc_pkg::FBC_MAX_IO && bit_tmp < 7'h10;
                fbc_pkg::FBC_AREA_LINK:
                    addr_ok = word_bin <= fbc_pkg::FBC_MAX_LINK && bit_tmp < 7'h10;
                fbc_pkg::FBC_AREA_HOLD:
                    addr_ok = word_bin <= fbc_pkg::FBC_MAX_HOLD && bit_tmp < 7'h10;
                fbc_pkg::FBC_AREA_AUX:
                    addr_ok = word_bin <= fbc_pkg::FBC_MAX_AUX && bit_tmp < 7'h10;
                fbc_pkg::FBC_AREA_TRANS:
                    // no program check on transition flags
                    addr_ok = word_bin <= fbc_pkg::FBC_MAX_TRANS && bit_tmp == 7'h00;
                fbc_pkg::FBC_AREA_BAD:
                    addr_ok = 1'b0;
                default:
                    addr_ok = word_bin <= fbc_pkg::FBC_MAX_CF && bit_tmp == 7'h00;
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- sim/fbc_host.sv ----
// host model: presents parsed forcing commands and collects the answers
`timescale 1ns/1ns
`default_nettype none
module fbc_host (
    input  wire logic            core_clk,
    input  wire logic            rsp_valid,
    input  wire logic [7:0]      rsp_code,
    output var fbc_pkg::fbc_cmd_type cmd_code,
    output logic                 cmd_valid,
    output logic [7:0]           cmd_len,
    output logic                 cmd_fcs_bad,
    output logic                 cmd_frame_bad,
    output logic [31:0]          cmd_operand,
    output logic [15:0]          cmd_word,
    output logic [7:0]           cmd_bit,
    output logic [63:0]          cmd_ops
);
    initial begin
        {cmd_valid, cmd_len, cmd_fcs_bad, cmd_frame_bad} = '0;
        {cmd_operand, cmd_word, cmd_bit, cmd_ops} = '0;
        cmd_code = fbc_pkg::FBC_CMD_SET;
    end
    // sends every field as given; timer/counter bit and ops are not limited here
    task automatic send(input fbc_pkg::fbc_cmd_type c, input logic [7:0] l,
            input logic [1:0] err, input logic [31:0] op,
            input logic [15:0] w, input logic [7:0] b,
            input logic [63:0] ops, output logic [8:0] got);
        // sometimes slow between frames
        repeat ($urandom_range(0, 2)) @(posedge core_clk);
        @(posedge core_clk);
        cmd_valid <= 1'b1;
        cmd_code <= c;
        cmd_len <= l;
        {cmd_fcs_bad, cmd_frame_bad} <= err;
        {cmd_operand, cmd_word, cmd_bit, cmd_ops} <= {op, w, b, ops};
        @(posedge core_clk);
        cmd_valid <= 1'b0;
        // released fields carry garbage so stale data cannot pass
        {cmd_operand, cmd_word, cmd_bit, cmd_ops} <= ~{op, w, b, ops};
        #1 got = {rsp_valid, rsp_code};
    endtask
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// bench: random and corner forcing commands against the handler
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic core_clk, nrst, cmd_valid, cmd_fcs_bad, cmd_frame_bad, prog_we;
    logic rsp_valid;
    fbc_pkg::fbc_cmd_type cmd_code;
    logic [7:0]  cmd_len, cmd_bit, rsp_code;
    logic [31:0] cmd_operand, e;
    logic [15:0] cmd_word, prog_data, rd_data, rd_forced, w;
    logic [63:0] cmd_ops, ops;
    logic [8:0]  prog_addr, rd_addr;
    logic [1:0]  plc_mode;
    int num_errors = 0, comparisons = 0, cycles = 0, n = 0, j;
    localparam logic [31:0] op_io = 32'h4349_4f20, op_link = 32'h4c52_2020;
    localparam logic [31:0] op_timer = 32'h5449_4d20, op_trn = 32'h544e_2020;
    localparam logic [23:0] opc = 24'h02_3458;
    fbc_handler dut (.core_clk, .nrst, .cmd_valid, .cmd_code, .cmd_len,
        .cmd_fcs_bad, .cmd_frame_bad, .cmd_operand, .cmd_word, .cmd_bit,
        .cmd_ops, .plc_mode, .prog_we, .prog_addr, .prog_data, .rd_addr,
        .rsp_valid, .rsp_code, .rd_data, .rd_forced);
    fbc_host host (.core_clk, .rsp_valid, .rsp_code, .cmd_code, .cmd_valid,
        .cmd_len, .cmd_fcs_bad, .cmd_frame_bad, .cmd_operand, .cmd_word,
        .cmd_bit, .cmd_ops);
    // ********************
    // helpers
    // ********************
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic t(input fbc_pkg::fbc_cmd_type c, input logic [7:0] adj,
            input logic [1:0] err, input logic [31:0] op,
            input logic [15:0] wd, input logic [7:0] b,
            input logic [63:0] o, input logic run, input logic [7:0] exp);
        logic [7:0] len;
        logic [8:0] got;
        len = (c == fbc_pkg::FBC_CMD_MULTI) ? fbc_pkg::FBC_LEN_MULTI :
            (c == fbc_pkg::FBC_CMD_CANCEL) ? 8'h00 : fbc_pkg::FBC_LEN_SINGLE;
        plc_mode <= run ? fbc_pkg::FBC_MODE_RUN : ($urandom_range(0, 1) ?
            fbc_pkg::FBC_MODE_MONITOR : fbc_pkg::FBC_MODE_PROGRAM);
        host.send(c, len + adj, err, op, wd, b, o, got);
        chk(got, {1'b1, exp});
        n++;
        $display("test %0d done", n);
    endtask
    task automatic pw(input logic [8:0] a, input logic [15:0] d);
        @(posedge core_clk);
        {prog_we, prog_addr, prog_data} <= {1'b1, a, d};
        @(posedge core_clk);
        prog_we <= 1'b0;
    endtask
    task automatic rd(input logic [8:0] a, input logic [15:0] ef,
            input logic [15:0] ed);
        @(posedge core_clk);
        rd_addr <= a;
        @(posedge core_clk);
        #1 chk({rd_forced, rd_data}, {ef, ed});
    endtask
    // per-bit effect of multi-force data on an unforced word
    function automatic logic [31:0] model(input logic [15:0] d,
            input logic [63:0] o);
        logic [15:0] fm;
        fm = '0;
        for (int i = 0; i < 16; i++) begin
            case (o[4*i+:4])
                4'h2: d[i] = 1'b0;
                4'h3: d[i] = 1'b1;
                4'h4: {fm[i], d[i]} = 2'b10;
                4'h5: {fm[i], d[i]} = 2'b11;
                default: ;
            endcase
        end
        return {fm, d};
    endfunction
    // ********************
    // sequence
    // ********************
    initial begin
        core_clk = 0;
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            wrap_up;
        end
    end
    initial begin
        {nrst, prog_we, prog_addr, prog_data, rd_addr, plc_mode} = '0;
        void'($urandom(38));
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        #1 chk({rsp_valid, rsp_code, rd_data, rd_forced}, 0);
        t(fbc_pkg::FBC_CMD_SET, 0, 0, op_io, 16'h0010, 8'h03, 0, 0, 0);
        t(fbc_pkg::FBC_CMD_RESET, 0, 0, op_io, 16'h0010, 8'h04, 0, 0, 0);
        t(fbc_pkg::FBC_CMD_SET, 1, 0, op_io, 16'h0010, 5, 0, 0, 8'h14);
        t(fbc_pkg::FBC_CMD_SET, 0, 3, op_io, 16'h0010, 5, 0, 0, 8'h13);
        t(fbc_pkg::FBC_CMD_SET, 0, 1, op_io, 16'h0010, 5, 0, 0, 8'h18);
        t(fbc_pkg::FBC_CMD_SET, 0, 0, op_io, 16'h0010, 5, 0, 1, 8'h01);
        t(fbc_pkg::FBC_CMD_SET, 0, 0, op_io, 16'h0254, 0, 0, 0, 8'h15);
        t(fbc_pkg::FBC_CMD_SET, 0, 0, op_io, 16'h0252, 8'h15, 0, 0, 0);
        t(fbc_pkg::FBC_CMD_SET, 0, 0, op_io, 16'h0010, 8'h16, 0, 0, 8'h15);
        t(fbc_pkg::FBC_CMD_SET, 0, 0, op_link, 16'h0064, 0, 0, 0, 8'h15);
        t(fbc_pkg::FBC_CMD_RESET, 0, 0, op_link, 16'h0063, 0, 0, 0, 0);
        t(fbc_pkg::FBC_CMD_SET, 0, 0, op_timer, 16'h0511, 1, 0, 0, 8'h15);
        t(fbc_pkg::FBC_CMD_SET, 0, 0, op_timer, 16'h0512, 0, 0, 0, 8'h15);
        t(fbc_pkg::FBC_CMD_MULTI, 0, 0, op_timer, 16'h0511, 0,
            {4'h5, 60'h222_2222_2222_2222}, 0, 0);
        t(fbc_pkg::FBC_CMD_MULTI, 0, 0, op_timer, 16'h0007, 0,
            64'h2000_0000_0000_0000, 0, 8'h15);
        t(fbc_pkg::FBC_CMD_SET, 0, 0, op_trn, 16'h1023, 0, 0, 0, 0);
        t(fbc_pkg::FBC_CMD_SET, 0, 0, op_trn, 16'h1024, 0, 0, 0, 8'h15);
        pw(10, 16'hffff);
        rd(10, 16'h0018, 16'hffef);
        t(fbc_pkg::FBC_CMD_MULTI, 0, 0, op_io, 16'h0010, 0,
            64'h0000_0000_0000_8000, 0, 0);
        pw(10, 16'h0000);
        rd(10, 16'h0010, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            w = 16'($urandom);
            pw(9'(20 + k), w);
            for (int i = 0; i < 16; i++) begin
                j = $urandom_range(0, 5);
                ops[4*i+:4] = opc[4*j+:4];
            end
            e = model(w, ops);
            t(fbc_pkg::FBC_CMD_MULTI, 0, 0, op_io, 16'h0020 + 16'(k), 0,
                ops, 0, 0);
            rd(9'(20 + k), e[31:16], e[15:0]);
            w = 16'($urandom);
            pw(9'(20 + k), w);
            rd(9'(20 + k), e[31:16], (w & ~e[31:16]) | (e[15:0] & e[31:16]));
        end
        t(fbc_pkg::FBC_CMD_CANCEL, 0, 0, 0, 0, 0, 0, 1, 0);
        pw(10, 16'h1234);
        rd(10, 16'h0000, 16'h1234);
        wrap_up;
    end
endmodule
`default_nettype wire
